// [verilog/dioirq_pkg.sv]
package dioirq_pkg;

    // Geometry
    localparam int NUM_PORTS = 12;
    localparam int PORT_W = 8;
    localparam int PIN_W = NUM_PORTS * PORT_W;
    localparam int NUM_CHAN = 4;

    // Register offsets in the I/O window
    localparam logic [7:0] ADDR_RESET_CTL = 8'h00;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h05;
    localparam logic [7:0] ADDR_IRQ_LEVEL = 8'h07;
    localparam logic [7:0] ADDR_PORT_BASE = 8'h10;
    localparam logic [7:0] ADDR_DIR_LO = 8'h20;
    localparam logic [7:0] ADDR_DIR_HI = 8'h21;
    localparam logic [7:0] ADDR_IRQ_POL = 8'h2a;

    // Field positions
    localparam int RESET_CTL_BIT = 0;
    localparam int DIR_LO_PORTS = 8;

    // Bit index of each channel source within the pin vector
    localparam int SRC_BIT_A = 2 * PORT_W;
    localparam int SRC_BIT_B = 5 * PORT_W;
    localparam int SRC_BIT_C = 8 * PORT_W;
    localparam int SRC_BIT_D = 11 * PORT_W;

    // Reset values
    localparam logic RST_OPS_EN = 1'b0;
    localparam logic [NUM_PORTS-1:0] RST_DIR = 12'h000;
    localparam logic [PORT_W-1:0] RST_LATCH_BYTE = 8'h00;
    localparam logic [NUM_CHAN-1:0] RST_IRQ_EN = 4'h0;
    localparam logic [NUM_CHAN-1:0] RST_IRQ_POL = 4'h0;
    localparam logic [7:0] RDATA_IDLE = 8'h00;

    // Host-side register access
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } dioirq_io_req_t;

    // Whole state of the block
    typedef struct packed {
        logic ops_en;
        logic [NUM_PORTS-1:0] dir;
        logic [PIN_W-1:0] latch;
        logic [NUM_CHAN-1:0] irq_en;
        logic [NUM_CHAN-1:0] pol;
        logic [PIN_W-1:0] sync1;
        logic [PIN_W-1:0] sync2;
        logic [7:0] rdata;
        logic rvalid;
        logic irq_n;
    } dioirq_state_t;

endpackage

// [verilog/dioirq_top.sv]
`timescale 1ns/100ps
// Summary of operation
// [RULE_01] Twelve byte ports, each input or latched output
// [RULE_02] Every port comes up as input
// [RULE_03] Port operations start disabled, latches unwritten
// [RULE_04] Low reset control disables ports, high enables
// [RULE_05] Input port read returns pin levels
// [RULE_06] Output port read returns latch value
// [RULE_07] Write to input port only updates latch
// [RULE_08] Four channels sourced from ports 2,5,8,11
// [RULE_09] Host interrupt is active-low level output
// [RULE_10] Channels equal priority, one shared interrupt
// [RULE_11] Per-channel enable, one enables
// [RULE_12] Polarity zero inverts source, one passes it
// [RULE_13] Software sets polarity so channel idles low
// [RULE_14] Software flips polarity each interrupt for pulses
// [RULE_15] Software compares saved levels, toggles changed
// [RULE_16] Source should hold about 20ms
// [RULE_17] Offset 0x2a write sets channel polarities
// [RULE_18] Software enables ports before configuring them
// [RULE_19] Offset 7 read shows four channel levels
// [RULE_20] Interrupt is NOR of enabled channels
module dioirq_top
    import dioirq_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // Host register port
    input wire logic [7:0] i_io_addr,
    input wire logic i_io_wr,
    input wire logic i_io_rd,
    input wire logic [7:0] i_io_wdata,
    output logic [7:0] o_io_rdata,
    output logic o_io_rdata_valid,
    // Port pins
    input wire logic [PIN_W-1:0] i_port_pins,
    output logic [PIN_W-1:0] o_port_out,
    output logic [PIN_W-1:0] o_port_oe,
    // Host interrupt
    output logic o_host_irq_n
);

    dioirq_state_t st_ff;
    dioirq_state_t nxt_st;
    dioirq_io_req_t req;
    logic [NUM_CHAN-1:0] src;
    logic [NUM_CHAN-1:0] chan;
    logic [PIN_W-1:0] view;

    // True when the address hits one of the port data registers
    function automatic logic is_port(input logic [7:0] addr);
        is_port = (addr >= ADDR_PORT_BASE) &&
                  (addr < ADDR_PORT_BASE + 8'(NUM_PORTS));
    endfunction

    // Port number selected by a port data address
    function automatic logic [3:0] port_index(input logic [7:0] addr);
        logic [7:0] diff;
        diff = addr - ADDR_PORT_BASE;
        port_index = diff[3:0];
    endfunction

    // Group host request signals
    assign req = '{addr: i_io_addr, wr: i_io_wr, rd: i_io_rd,
                   wdata: i_io_wdata};

    // Visible level of each port bit: pins or read-back latch
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            view[p*PORT_W +: PORT_W] = st_ff.dir[p] ?
                st_ff.latch[p*PORT_W +: PORT_W] : // [RULE_06]
                st_ff.sync2[p*PORT_W +: PORT_W];  // [RULE_05]
        end
    end

    // Channel sources and polarity selection
    assign src = {view[SRC_BIT_D], view[SRC_BIT_C],
                  view[SRC_BIT_B], view[SRC_BIT_A]}; // [RULE_08]
    assign chan = ~(src ^ st_ff.pol); // [RULE_12]

    // Next-state logic
    always_comb begin
        nxt_st = st_ff;
        nxt_st.sync1 = i_port_pins;
        nxt_st.sync2 = st_ff.sync1;
        nxt_st.rvalid = req.rd;
        nxt_st.rdata = RDATA_IDLE;
        // Single merged level, equal priority, active low
        nxt_st.irq_n = // [RULE_09] [RULE_10]
            ~|(st_ff.irq_en & chan); // [RULE_11] [RULE_20]
        if (req.wr) begin
            case (req.addr)
                ADDR_RESET_CTL: begin
                    nxt_st.ops_en = req.wdata[RESET_CTL_BIT]; // [RULE_04]
                end
                ADDR_IRQ_EN: begin
                    nxt_st.irq_en = req.wdata[NUM_CHAN-1:0]; // [RULE_11]
                end
                ADDR_IRQ_POL: begin
                    nxt_st.pol = req.wdata[NUM_CHAN-1:0]; // [RULE_17]
                end
                ADDR_DIR_LO: begin
                    if (st_ff.ops_en) begin
                        nxt_st.dir[DIR_LO_PORTS-1:0] = req.wdata; // [RULE_01]
                    end
                end
                ADDR_DIR_HI: begin
                    if (st_ff.ops_en) begin
                        nxt_st.dir[NUM_PORTS-1:DIR_LO_PORTS] =
                            req.wdata[NUM_PORTS-DIR_LO_PORTS-1:0];
                    end
                end
                default: begin
                    // Latch takes the write only while ports are enabled, pins follow dir
                    if (is_port(req.addr) && st_ff.ops_en) begin
                        nxt_st.latch[port_index(req.addr)*PORT_W +: PORT_W]
                            = req.wdata; // [RULE_07]
                    end
                end
            endcase
        end
        if (req.rd) begin
            case (req.addr)
                ADDR_RESET_CTL: begin
                    nxt_st.rdata = {7'h00, st_ff.ops_en};
                end
                ADDR_IRQ_EN: begin
                    nxt_st.rdata = {4'h0, st_ff.irq_en};
                end
                ADDR_IRQ_LEVEL: begin
                    nxt_st.rdata = {4'h0, src}; // [RULE_19]
                end
                ADDR_DIR_LO: begin
                    nxt_st.rdata = st_ff.dir[DIR_LO_PORTS-1:0];
                end
                ADDR_DIR_HI: begin
                    nxt_st.rdata = {4'h0, st_ff.dir[NUM_PORTS-1:DIR_LO_PORTS]};
                end
                default: begin
                    if (is_port(req.addr) && st_ff.ops_en) begin
                        nxt_st.rdata =
                            view[port_index(req.addr)*PORT_W +: PORT_W];
                    end
                end
            endcase
        end
    end

    // State register with synchronous reset
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            st_ff.ops_en <= RST_OPS_EN; // [RULE_03]
            st_ff.dir <= RST_DIR; // [RULE_02]
            st_ff.latch <= {NUM_PORTS{RST_LATCH_BYTE}};
            st_ff.irq_en <= RST_IRQ_EN;
            st_ff.pol <= RST_IRQ_POL;
            st_ff.sync1 <= {NUM_PORTS{RST_LATCH_BYTE}};
            st_ff.sync2 <= {NUM_PORTS{RST_LATCH_BYTE}};
            st_ff.rdata <= RDATA_IDLE;
            st_ff.rvalid <= 1'b0;
            st_ff.irq_n <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Pin drivers: enabled only for output ports while operating
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            o_port_oe[p*PORT_W +: PORT_W] =
                {PORT_W{st_ff.dir[p] & st_ff.ops_en}}; // [RULE_04]
        end
    end
    assign o_port_out = st_ff.latch;
    assign o_io_rdata = st_ff.rdata;
    assign o_io_rdata_valid = st_ff.rvalid;
    assign o_host_irq_n = st_ff.irq_n;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);

    property p_dir_reset;
        $past(i_reset) |-> (st_ff.dir == RST_DIR);
    endproperty
    a_dir_reset: assert property (p_dir_reset) // [RULE_02]
        else $error("ports not input after reset");

    property p_ops_reset;
        $past(i_reset) |-> (!st_ff.ops_en && o_port_oe == '0);
    endproperty
    a_ops_reset: assert property (p_ops_reset) // [RULE_03]
        else $error("ports enabled after reset");

    property p_disabled_no_drive;
        !st_ff.ops_en |-> (o_port_oe == '0);
    endproperty
    a_disabled_no_drive: assert property (p_disabled_no_drive) // [RULE_04]
        else $error("pin driven while disabled");

    property p_read_input;
        (req.rd && req.addr == ADDR_PORT_BASE && st_ff.ops_en &&
         !st_ff.dir[0]) |=> (o_io_rdata == $past(st_ff.sync2[7:0]) &&
                             o_io_rdata_valid);
    endproperty
    a_read_input: assert property (p_read_input) // [RULE_05]
        else $error("input port read not pin level");

    property p_read_output;
        (req.rd && req.addr == ADDR_PORT_BASE && st_ff.ops_en &&
         st_ff.dir[0]) |=> (o_io_rdata == $past(st_ff.latch[7:0]));
    endproperty
    a_read_output: assert property (p_read_output) // [RULE_06]
        else $error("output port read not latch");

    property p_write_input;
        (req.wr && req.addr == ADDR_PORT_BASE && st_ff.ops_en &&
         !st_ff.dir[0]) |=> (o_port_out[7:0] == $past(req.wdata) &&
                             o_port_oe[7:0] == 8'h00);
    endproperty
    a_write_input: assert property (p_write_input) // [RULE_07]
        else $error("write to input port misbehaved");

    property p_irq_level;
        ##1 (o_host_irq_n == !$past(|(st_ff.irq_en & chan)));
    endproperty
    a_irq_level: assert property (p_irq_level) // [RULE_20]
        else $error("interrupt not nor of channels");

    property p_irq_disabled;
        (st_ff.irq_en == 4'h0) [*2] |-> o_host_irq_n;
    endproperty
    a_irq_disabled: assert property (p_irq_disabled) // [RULE_11]
        else $error("interrupt with channels disabled");

    property p_pol_invert;
        (st_ff.irq_en[0] && !st_ff.pol[0] && !src[0]) |=> !o_host_irq_n;
    endproperty
    a_pol_invert: assert property (p_pol_invert) // [RULE_12]
        else $error("inverted low source gave no interrupt");

    property p_pol_write;
        (req.wr && req.addr == ADDR_IRQ_POL) |=>
            (st_ff.pol == $past(req.wdata[3:0]));
    endproperty
    a_pol_write: assert property (p_pol_write) // [RULE_17]
        else $error("polarity write lost");

    property p_level_read;
        (req.rd && req.addr == ADDR_IRQ_LEVEL) |=>
            (o_io_rdata == {4'h0, $past(src)});
    endproperty
    a_level_read: assert property (p_level_read) // [RULE_19]
        else $error("level status read wrong");

endmodule

// [verif/dioirq_host.sv]
`timescale 1ns/100ps
module dioirq_host
    import dioirq_pkg::*;
(
    // Clock
    input wire logic i_ref_clk,
    // Register port towards the block
    output logic [7:0] o_io_addr,
    output logic o_io_wr,
    output logic o_io_rd,
    output logic [7:0] o_io_wdata
);
    logic [3:0] pol = 4'h0;
    logic [3:0] saved = 4'h0;
    // Idle bus at time zero
    initial begin
        o_io_addr = 8'hff;
        o_io_wr = 1'b0;
        o_io_rd = 1'b0;
        o_io_wdata = 8'hff;
    end
    // One write; afterwards the bus shows inverted leftovers
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        o_io_addr <= a;
        o_io_wdata <= d;
        o_io_wr <= 1'b1;
        @(posedge i_ref_clk);
        o_io_wr <= 1'b0;
        o_io_addr <= ~a;
        o_io_wdata <= ~d;
    endtask
    // One read strobe; data comes back a cycle later
    task automatic rd(input logic [7:0] a);
        @(posedge i_ref_clk);
        o_io_addr <= a;
        o_io_rd <= 1'b1;
        @(posedge i_ref_clk);
        o_io_rd <= 1'b0;
        o_io_addr <= ~a;
    endtask
    // Pick polarity so every channel rests low, then enable all
    task automatic init(input logic [3:0] idle);
        pol = ~idle;
        saved = idle;
        wr(ADDR_IRQ_POL, {4'h0, pol});
        wr(ADDR_IRQ_EN, 8'h0f);
    endtask
    // Service pass: flip polarity of each channel whose level moved
    task automatic service(input logic [3:0] lvl);
        pol = pol ^ (lvl ^ saved);
        saved = lvl;
        wr(ADDR_IRQ_POL, {4'h0, pol});
    endtask
endmodule

// [verif/tb_top.sv]
`timescale 1ns/100ps
module tb_top
    import dioirq_pkg::*;
;
    logic i_ref_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [PIN_W-1:0] pins = '0;
    logic [PIN_W-1:0] o_port_out, o_port_oe;
    logic [7:0] io_addr, io_wdata, o_io_rdata, d, e;
    logic io_wr, io_rd, o_io_rdata_valid, o_host_irq_n;
    logic [7:0] exp_q[$];
    logic [3:0] lvl;
    int n_fail = 0;
    int samples_checked = 0;
    int seed = 37593;
    // Clock at 25 MHz
    always #20 i_ref_clk = ~i_ref_clk;
    dioirq_host host (.i_ref_clk(i_ref_clk), .o_io_addr(io_addr),
        .o_io_wr(io_wr), .o_io_rd(io_rd), .o_io_wdata(io_wdata));
    dioirq_top DUT (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
        .i_io_addr(io_addr), .i_io_wr(io_wr), .i_io_rd(io_rd),
        .i_io_wdata(io_wdata), .o_io_rdata(o_io_rdata),
        .o_io_rdata_valid(o_io_rdata_valid), .i_port_pins(pins),
        .o_port_out(o_port_out), .o_port_oe(o_port_oe),
        .o_host_irq_n(o_host_irq_n));
    task automatic complete_run();
        if (exp_q.size() > 0) chk_val("pending", 8'h00, 8'(exp_q.size()));
        $display("compares %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk_val(input string nm, input logic [7:0] x, y);
        samples_checked++;
        if (y !== x) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, x, y);
        end
    endtask
    task automatic chk_irq(input logic x);
        samples_checked++;
        if (o_host_irq_n !== x) begin
            n_fail++;
            $display("unexpected irq_n expected %b seen %b", x, o_host_irq_n);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    // Note the expected byte, then issue the read
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        exp_q.push_back(x);
        host.rd(a);
        settle(2);
    endtask
    task automatic set_src(input logic [3:0] l);
        @(posedge i_ref_clk);
        pins[SRC_BIT_A] <= l[0];
        pins[SRC_BIT_B] <= l[1];
        pins[SRC_BIT_C] <= l[2];
        pins[SRC_BIT_D] <= l[3];
    endtask
    // Read results are matched against the oldest note
    always @(negedge i_ref_clk) begin
        if (o_io_rdata_valid === 1'b1) begin
            if (exp_q.size() > 0)
                chk_val("rdata", exp_q.pop_front(), o_io_rdata);
            else chk_val("rdata_spare", 8'h00, 8'hxx);
        end
    end
    // Watchdog
    initial begin
        #400_000;
        n_fail++;
        complete_run();
    end
    // Main sequence
    initial begin
        pins = {$random(seed), $random(seed), $random(seed)};
        d = $random(seed);
        e = $random(seed);
        repeat (12) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        set_src(4'h0);
        host.wr(ADDR_PORT_BASE + 8'h03, 8'h5a);
        host.wr(ADDR_DIR_LO, 8'h08);
        rd(ADDR_PORT_BASE + 8'h03, 8'h00);
        chk_val("oe3", 8'h00, o_port_oe[31:24]);
        host.wr(ADDR_RESET_CTL, 8'h01);
        rd(ADDR_PORT_BASE + 8'h03, pins[31:24]);
        host.wr(ADDR_PORT_BASE + 8'h04, d);
        rd(ADDR_PORT_BASE + 8'h04, pins[39:32]);
        chk_val("oe4", 8'h00, o_port_oe[39:32]);
        host.wr(ADDR_DIR_LO, 8'h18);
        host.wr(ADDR_PORT_BASE + 8'h03, e);
        rd(ADDR_PORT_BASE + 8'h04, d);
        rd(ADDR_PORT_BASE + 8'h03, e);
        chk_val("out4", d, o_port_out[39:32]);
        chk_val("oe4", 8'hff, o_port_oe[39:32]);
        chk_val("oe5", 8'h00, o_port_oe[47:40]);
        host.wr(ADDR_RESET_CTL, 8'h00);
        settle(2);
        chk_val("oe4", 8'h00, o_port_oe[39:32]);
        rd(ADDR_PORT_BASE + 8'h04, 8'h00);
        rd(8'h3f, 8'h00);
        rd(ADDR_IRQ_POL, 8'h00);
        $display("test ports done");
        host.init(4'h0);
        settle(4);
        chk_irq(1'b1);
        lvl = 4'h0;
        for (int c = 0; c < NUM_CHAN; c++) begin
            lvl[c] = 1'b1;
            set_src(lvl);
            settle(4);
            chk_irq(1'b0);
            rd(ADDR_IRQ_LEVEL, {4'h0, lvl});
            host.service(lvl);
            settle(4);
            chk_irq(1'b1);
        end
        lvl = 4'ha;
        set_src(lvl);
        settle(4);
        chk_irq(1'b0);
        rd(ADDR_IRQ_LEVEL, {4'h0, lvl});
        host.service(lvl);
        settle(4);
        chk_irq(1'b1);
        host.wr(ADDR_IRQ_EN, 8'h0a);
        host.wr(ADDR_IRQ_POL, 8'h00);
        settle(4);
        chk_irq(1'b1);
        host.wr(ADDR_IRQ_EN, 8'h04);
        settle(4);
        chk_irq(1'b0);
        $display("test interrupts done");
        // Mid-run reset, then exercise port 0 in both directions
        @(posedge i_ref_clk);
        i_reset <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        rd(ADDR_PORT_BASE + 8'h04, 8'h00);
        chk_irq(1'b1);
        host.wr(ADDR_RESET_CTL, 8'h01);
        rd(ADDR_DIR_LO, 8'h00);
        chk_val("oe4", 8'h00, o_port_oe[39:32]);
        rd(ADDR_PORT_BASE, pins[7:0]);
        host.wr(ADDR_PORT_BASE, d);
        settle(1);
        chk_val("oe0", 8'h00, o_port_oe[7:0]);
        chk_val("out0", d, o_port_out[7:0]);
        host.wr(ADDR_DIR_LO, 8'h01);
        rd(ADDR_PORT_BASE, d);
        chk_val("oe0", 8'hff, o_port_oe[7:0]);
        $display("test reset done");
        complete_run();
    end
endmodule
